//--- core/mib_pkg.sv
/*
 Shared constants, types and word-packing helpers for the I/O buffer board.
 Assumes a single 40 MHz clock and synchronous inputs from all parties.
*/
// Notes on behaviour
// - Each channel adapter reaches only its own 65,536-word 72-bit buffer.
// - Processor n reaches buffers 4n to 4n+3 only.
// - Processor references to another processor's buffers are blocked.
// - Either high-speed channel may address any of the 16 buffers.
// - Channel 1 is local for buffer groups 0-3 and 8-11; channel 0 mirrors.
// - Adapters use lower pointers; channels and processors use upper pointers.
// - Each pointer set gets one memory access every sync cycle.
// - Adapter pointers step up or down as programmed.
// - High-speed channel beats processor for the upper pointer slot.
// - A sync pulse is produced once every six clock periods.
// - Period 2 serves adapters, period 5 serves channels and processors.
// - Check bits are generated on processor write data and stored.
// - Processor read data is corrected and double errors flagged.
// - High-speed data is corrected on arrival and again on departure.
// - Adapter data is stored and returned with no checking.
// - Memory words are two halves of 32 data and 4 check bits.
// - Write source per slot: processor, local or remote channel, adapter.
// - Arriving channel data with check bits is corrected before storing.
// - A pointer-select encode picks which pointer loads; it drives address.
// - Error status returns to processor port and channel output separately.
// - Processor reference colliding with a channel is aborted.
// - Strobe at sync+4 selects pointer B; at sync+5 makes the reference.
package mib_pkg;
	localparam int BUF_AW = 16;
	localparam int BUF_SEL_W = 4;
	localparam int WORD_W = 72;
	localparam int DATA_W = 64;
	localparam int CB_W = 8;
	localparam int HALF_W = 36;
	localparam int HALF_DATA_W = 32;
	localparam int HALF_CB_W = 4;
	localparam int MEM_WORDS = 1 << (BUF_AW + BUF_SEL_W);
	localparam int CA_FIFO_DEPTH = 32;
	localparam int OWNER_LSB = 2;
	localparam logic SIDE_BIT_LOCAL1 = 1'b0;
	localparam logic [1:0] PTR_LA = 2'h0;
	localparam logic [1:0] PTR_LB = 2'h1;
	localparam logic [1:0] PTR_UA = 2'h2;
	localparam logic [1:0] PTR_UB = 2'h3;
	localparam logic [BUF_AW-1:0] PTR_RESET = 16'h0000;

	typedef enum logic [2:0] {
		PH0 = 3'h0, PH1 = 3'h1, PH2 = 3'h3, PH3 = 3'h7, PH4 = 3'h6, PH5 = 3'h4
	} mib_phase_t;

	typedef enum logic [1:0] {
		SRC_IOP = 2'h0, SRC_HS_LOCAL = 2'h1, SRC_HS_REMOTE = 2'h2, SRC_CA = 2'h3
	} mib_src_t;

	typedef struct packed {
		logic valid;
		logic [BUF_SEL_W-1:0] buffer;
		logic [1:0] sel;
		logic down;
		logic [BUF_AW-1:0] addr;
	} mib_ptr_load_t;

	typedef struct packed {
		logic [BUF_SEL_W-1:0] adapter;
		logic useB;
		logic write;
		logic [WORD_W-1:0] data;
	} mib_ca_req_t;

	typedef struct packed {
		logic valid;
		logic chan;
		logic [BUF_SEL_W-1:0] buffer;
		logic useB;
		logic write;
		logic [CB_W-1:0] check;
		logic [DATA_W-1:0] data;
	} mib_hs_req_t;

	typedef struct packed {
		logic valid;
		logic [BUF_SEL_W-1:0] buffer;
		logic [WORD_W-1:0] word;
		logic single;
		logic dbl;
	} mib_rd_t;

	// Memory layout: {cb hi, data hi, cb lo, data lo}
	function automatic logic [WORD_W-1:0] packWord(
		input logic [DATA_W-1:0] d, input logic [CB_W-1:0] c);
		return {c[CB_W-1:HALF_CB_W], d[DATA_W-1:HALF_DATA_W],
			c[HALF_CB_W-1:0], d[HALF_DATA_W-1:0]};
	endfunction

	// Returns {check, data}
	function automatic logic [WORD_W-1:0] unpackWord(input logic [WORD_W-1:0] w);
		return {w[HALF_W+HALF_DATA_W+:HALF_CB_W], w[HALF_DATA_W+:HALF_CB_W],
			w[HALF_W+:HALF_DATA_W], w[HALF_DATA_W-1:0]};
	endfunction
endpackage

//--- core/mib_buffer_board.sv
/*
 Buffer board core: sync generator, adapter request FIFO, pointer files,
 slot arbitration, check-bit generation and correction, buffer memory.
 Assumes all requesters present requests synchronous to clk and hold
 processor and channel requests through the period-5 slot.
*/
`timescale 1ns/1ps
`default_nettype none

module mib_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = DEPTH[AW:0];
	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign inReady = count != FULL;
	assign outValid = count != '0;
	assign outData = store[rdPtr];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_ff @(posedge clk) begin
		if (push) begin
			store[wrPtr] <= inData;
		end
	end

	// Depth is a power of two, so pointers wrap naturally
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= rdPtr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module mib_buffer_board (
	input wire logic clk,
	input wire logic rst_b,
	output logic syncPulse,
	input wire mib_pkg::mib_ptr_load_t ptrLoad,
	input wire logic caReqValid,
	output logic caReqReady,
	input wire mib_pkg::mib_ca_req_t caReq,
	output mib_pkg::mib_rd_t caRd,
	input wire logic [1:0] iopId,
	input wire logic bufferSelectStrobe,
	input wire logic readFlag,
	input wire logic [mib_pkg::BUF_SEL_W-1:0] iopBuffer,
	input wire logic [mib_pkg::DATA_W-1:0] iopWrData,
	output logic iopAbort,
	output logic iopReject,
	output mib_pkg::mib_rd_t iopRd,
	input wire mib_pkg::mib_hs_req_t hsReq,
	output logic hsLocal,
	output logic [1:0] hsInStatus,
	output mib_pkg::mib_rd_t hsRd,
	output logic [mib_pkg::BUF_AW-1:0] memAddr,
	output mib_pkg::mib_src_t memSource
);
	import mib_pkg::*;

	mib_phase_t phase, next_phase;
	logic caHeadValid;
	logic [$bits(mib_ca_req_t)-1:0] caHeadBits;
	mib_ca_req_t caHead;
	logic caDo, hsDo, iopDo, iopRef, iopOwned, accDo, memWe, hsLocalNow;
	logic iopSelB;
	logic [BUF_SEL_W-1:0] accBuf;
	logic [1:0] accSel;
	logic [WORD_W-1:0] memWord;
	logic [BUF_AW-1:0] curPtr;
	mib_src_t accSrc;
	logic [BUF_AW-1:0] ptr [0:(1<<BUF_SEL_W)-1][0:3];
	logic ptrDown [0:(1<<BUF_SEL_W)-1][0:1];
	logic [WORD_W-1:0] mem [0:MEM_WORDS-1];
	logic [WORD_W-1:0] rdWord, rdCw;
	logic rdCa, rdIop, rdHs;
	logic [BUF_SEL_W-1:0] rdBuf;
	logic [DATA_W+1:0] hsInFix, rdFix;

	function automatic logic [CB_W-1:0] eccGen(input logic [DATA_W-1:0] d);
		logic [CB_W-1:0] c;
		int p;
		c = '0;
		p = 2;
		for (int k = 0; k < DATA_W; k++) begin
			p = p + 1;
			if ((p & (p - 1)) == 0) begin
				p = p + 1;
			end
			if (d[k]) begin
				c[CB_W-2:0] = c[CB_W-2:0] ^ p[CB_W-2:0];
			end
		end
		c[CB_W-1] = ^{d, c[CB_W-2:0]};
		return c;
	endfunction

	// Input {check, data}; returns {single, double, corrected data}
	function automatic logic [DATA_W+1:0] eccFix(input logic [WORD_W-1:0] cw);
		logic [DATA_W-1:0] d;
		logic [CB_W-1:0] g;
		logic [CB_W-2:0] syn;
		logic par;
		int p;
		d = cw[DATA_W-1:0];
		g = eccGen(d);
		syn = cw[WORD_W-2:DATA_W] ^ g[CB_W-2:0];
		par = ^cw;
		p = 2;
		for (int k = 0; k < DATA_W; k++) begin
			p = p + 1;
			if ((p & (p - 1)) == 0) begin
				p = p + 1;
			end
			if (par && p[CB_W-2:0] == syn) begin
				d[k] = ~d[k];
			end
		end
		return {par, (syn != '0) && !par, d};
	endfunction

	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	always_comb begin
		case (phase)
			PH0: next_phase = PH1;
			PH1: next_phase = PH2;
			PH2: next_phase = PH3;
			PH3: next_phase = PH4;
			PH4: next_phase = PH5;
			default: next_phase = PH0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase <= PH5;
			syncPulse <= 1'b0;
		end else begin
			phase <= next_phase;
			syncPulse <= next_phase == PH0;
		end
	end

	a_sync_period: assert property (syncPulse |=> !syncPulse [*5] ##1 syncPulse)
		else $error("sync pulse not every six periods");

	// Adapter requests queue here so slow slots push back on adapters
	mib_fifo #(.WIDTH($bits(mib_ca_req_t)), .DEPTH(CA_FIFO_DEPTH)) caFifo (
		.clk(clk),
		.rst_b(rst_b),
		.inValid(caReqValid),
		.inReady(caReqReady),
		.inData(caReq),
		.outValid(caHeadValid),
		.outReady(phase == PH2),
		.outData(caHeadBits)
	);
	assign caHead = mib_ca_req_t'(caHeadBits);

	assign caDo = caHeadValid && phase == PH2;
	assign hsDo = hsReq.valid && phase == PH5;
	assign iopRef = bufferSelectStrobe && phase == PH5;
	assign iopOwned = iopBuffer[OWNER_LSB+:2] == iopId;
	assign iopDo = iopRef && iopOwned && !hsReq.valid;
	assign accDo = caDo || hsDo || iopDo;
	assign hsLocalNow = (hsReq.buffer[OWNER_LSB] == SIDE_BIT_LOCAL1) == hsReq.chan;
	assign hsInFix = eccFix({hsReq.check, hsReq.data});

	// Pointer B select is latched one period ahead of the reference
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			iopSelB <= 1'b0;
		end else if (phase == PH4) begin
			iopSelB <= bufferSelectStrobe;
		end
	end

	always_comb begin
		accBuf = caHead.adapter;
		accSel = caHead.useB ? PTR_LB : PTR_LA;
		memWe = caDo && caHead.write;
		memWord = caHead.data;
		accSrc = SRC_CA;
		if (hsDo) begin
			accBuf = hsReq.buffer;
			accSel = hsReq.useB ? PTR_UB : PTR_UA;
			memWe = hsReq.write;
			memWord = packWord(hsInFix[DATA_W-1:0], eccGen(hsInFix[DATA_W-1:0]));
			accSrc = hsLocalNow ? SRC_HS_LOCAL : SRC_HS_REMOTE;
		end else if (iopDo) begin
			accBuf = iopBuffer;
			accSel = iopSelB ? PTR_UB : PTR_UA;
			memWe = !readFlag;
			memWord = packWord(iopWrData, eccGen(iopWrData));
			accSrc = SRC_IOP;
		end
	end
	assign curPtr = ptr[accBuf][accSel];

	// A load in the same cycle as an access wins, software restarts the walk
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int b = 0; b < (1 << BUF_SEL_W); b++) begin
				for (int s = 0; s < 4; s++) begin
					ptr[b][s] <= PTR_RESET;
				end
			end
		end else begin
			if (accDo) begin
				if (!accSel[1] && ptrDown[accBuf][accSel[0]]) begin
					ptr[accBuf][accSel] <= curPtr - 1'b1;
				end else begin
					ptr[accBuf][accSel] <= curPtr + 1'b1;
				end
			end
			if (ptrLoad.valid) begin
				ptr[ptrLoad.buffer][ptrLoad.sel] <= ptrLoad.addr;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int b = 0; b < (1 << BUF_SEL_W); b++) begin
				ptrDown[b][0] <= 1'b0;
				ptrDown[b][1] <= 1'b0;
			end
		end else if (ptrLoad.valid && !ptrLoad.sel[1]) begin
			ptrDown[ptrLoad.buffer][ptrLoad.sel[0]] <= ptrLoad.down;
		end
	end

	always_ff @(posedge clk) begin
		if (accDo && memWe) begin
			mem[{accBuf, curPtr}] <= memWord;
		end
		rdWord <= mem[{accBuf, curPtr}];
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdCa <= 1'b0;
			rdIop <= 1'b0;
			rdHs <= 1'b0;
			rdBuf <= '0;
			memAddr <= '0;
			memSource <= SRC_CA;
		end else begin
			rdCa <= caDo && !caHead.write;
			rdIop <= iopDo && readFlag;
			rdHs <= hsDo && !hsReq.write;
			rdBuf <= accBuf;
			if (accDo) begin
				memAddr <= curPtr;
				memSource <= accSrc;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			iopAbort <= 1'b0;
			iopReject <= 1'b0;
			hsLocal <= 1'b0;
			hsInStatus <= 2'h0;
		end else begin
			iopAbort <= iopRef && iopOwned && hsReq.valid;
			iopReject <= iopRef && !iopOwned;
			if (hsDo) begin
				hsLocal <= hsLocalNow;
				hsInStatus <= hsInFix[DATA_W+1:DATA_W];
			end
		end
	end

	assign rdCw = unpackWord(rdWord);
	assign rdFix = eccFix(rdCw);

	// One decoder serves both upper-pointer readers; only one can own a slot
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			caRd <= '0;
			iopRd <= '0;
			hsRd <= '0;
		end else begin
			caRd <= '{valid: rdCa, buffer: rdBuf, word: rdWord,
				single: 1'b0, dbl: 1'b0};
			iopRd <= '{valid: rdIop, buffer: rdBuf,
				word: {rdCw[WORD_W-1:DATA_W], rdFix[DATA_W-1:0]},
				single: rdFix[DATA_W+1], dbl: rdFix[DATA_W]};
			hsRd <= '{valid: rdHs, buffer: rdBuf,
				word: {rdCw[WORD_W-1:DATA_W], rdFix[DATA_W-1:0]},
				single: rdFix[DATA_W+1], dbl: rdFix[DATA_W]};
		end
	end

	// Helper for pointer-step check
	logic [BUF_SEL_W-1:0] chkBuf;
	logic [1:0] chkSel;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			chkBuf <= '0;
			chkSel <= PTR_LA;
		end else begin
			chkBuf <= accBuf;
			chkSel <= accSel;
		end
	end

	a_ca_slot: assert property (caRd.valid |-> phase == PH4 && $past(phase, 2) == PH2)
		else $error("adapter read outside its slot");

	a_upper_slot: assert property ((hsRd.valid || iopRd.valid) |-> phase == PH1)
		else $error("upper read outside its slot");

	a_owner_block: assert property ((phase == PH5 && bufferSelectStrobe && iopBuffer[3:2] != iopId) |=> iopReject ##1 !iopRd.valid)
		else $error("foreign buffer reference not blocked");

	a_hs_wins: assert property ((phase == PH5 && bufferSelectStrobe && hsReq.valid && iopBuffer[3:2] == iopId) |=> iopAbort ##1 !iopRd.valid)
		else $error("processor not aborted on channel collision");

	a_iop_read: assert property ((phase == PH5 && bufferSelectStrobe && readFlag && !hsReq.valid && iopBuffer[3:2] == iopId) |-> ##2 iopRd.valid && iopRd.buffer == $past(iopBuffer, 2))
		else $error("processor read not returned");

	a_hs_local: assert property ((phase == PH5 && hsReq.valid) |=> hsLocal == ($past(hsReq.chan) != $past(hsReq.buffer[2])))
		else $error("local or remote channel wrong");

	a_ptr_step: assert property ((accDo && !ptrLoad.valid && accSel[1]) |=> ptr[chkBuf][chkSel] == memAddr + 16'h0001)
		else $error("upper pointer did not advance");

	a_ca_raw: assert property (caRd.valid |-> !caRd.single && !caRd.dbl && memSource == SRC_CA)
		else $error("adapter data marked checked");
endmodule

`default_nettype wire

//--- bench/mib_ca_model.sv
/*
 Adapter-side partner: queues adapter requests, offers them on valid/ready.
 Assumes the board's ready depends only on its own FIFO fill.
*/
`timescale 1ns/1ps
`default_nettype none

module mib_ca_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic slow,
	output logic caReqValid,
	input wire logic caReqReady,
	output mib_pkg::mib_ca_req_t caReq
);
	import mib_pkg::*;
	mib_ca_req_t q[$];
	logic took;

	task automatic push(input mib_ca_req_t r);
		q.push_back(r);
	endtask

	// Request held until ready is seen high at an edge
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			caReqValid <= 1'b0;
			caReq <= '0;
		end else begin
			took = caReqValid && caReqReady;
			if (took)
				void'(q.pop_front());
			// Slow mode leaves a gap after each transfer
			if (q.size() > 0 && !(slow && took)) begin
				caReqValid <= 1'b1;
				caReq <= q[0];
			end else begin
				caReqValid <= 1'b0;
				caReq <= ~caReq; // Released lines must not keep old value
			end
		end
	end
endmodule

`default_nettype wire

//--- bench/test_multiport_io_buffer_memory.sv
/*
 Self-checking bench for the buffer board: sync, processor, high-speed
 and adapter ports, FIFO fill and drain.
 Assumes the hand-over timing: period-5 references, answers at +1 and +2.
*/
`timescale 1ns/1ps
`default_nettype none

module test_multiport_io_buffer_memory;
	import mib_pkg::*;
	localparam logic [63:0] D1 = 64'h0123_4567_89AB_CDEF;
	localparam logic [63:0] D2 = 64'hFEDC_BA98_7654_3210;
	localparam logic [71:0] W1 = 72'hA5_0F1E_2D3C_4B5A_6978;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic slow = 1'b0;
	logic syncPulse, caReqValid, caReqReady, iopAbort, iopReject, hsLocal;
	logic bufferSelectStrobe = 1'b0;
	logic readFlag = 1'b0;
	logic [1:0] iopId = '0;
	logic [3:0] iopBuffer = '0;
	logic [63:0] iopWrData = '0;
	logic [1:0] hsInStatus;
	logic [15:0] memAddr;
	logic [7:0] cb1;
	mib_ptr_load_t ptrLoad = '0;
	mib_hs_req_t hsReq = '0;
	mib_ca_req_t caReq;
	mib_rd_t caRd, iopRd, hsRd;
	mib_src_t memSource;
	int miscompares = 0;
	int checkCount = 0;

	always #12.5 clk = ~clk;

	mib_buffer_board dut (.clk(clk), .rst_b(rst_b), .syncPulse(syncPulse),
		.ptrLoad(ptrLoad), .caReqValid(caReqValid), .caReqReady(caReqReady),
		.caReq(caReq), .caRd(caRd), .iopId(iopId),
		.bufferSelectStrobe(bufferSelectStrobe), .readFlag(readFlag),
		.iopBuffer(iopBuffer), .iopWrData(iopWrData), .iopAbort(iopAbort),
		.iopReject(iopReject), .iopRd(iopRd), .hsReq(hsReq),
		.hsLocal(hsLocal), .hsInStatus(hsInStatus), .hsRd(hsRd),
		.memAddr(memAddr), .memSource(memSource));
	mib_ca_model ca (.clk(clk), .rst_b(rst_b), .slow(slow),
		.caReqValid(caReqValid), .caReqReady(caReqReady), .caReq(caReq));

	task automatic chk(input logic [71:0] got, input logic [71:0] exp);
		checkCount++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wrapUp;
		$display("checks %0d mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Returns just after the edge that opens period k (k=0: period-0 negedge)
	task automatic toPhase(input int k);
		@(negedge clk);
		while (syncPulse !== 1'b1)
			@(negedge clk);
		repeat (k) @(posedge clk);
	endtask

	task automatic ld(input logic [3:0] b, input logic [1:0] s,
		input logic dn, input logic [15:0] a);
		@(posedge clk);
		ptrLoad <= '{valid:1'b1, buffer:b, sel:s, down:dn, addr:a};
		@(posedge clk);
		ptrLoad.valid <= 1'b0;
	endtask

	// Ends at the negedge of the cycle after the period-5 reference
	task automatic iopRef(input logic [1:0] id, input logic [3:0] b,
		input logic rd, input logic [63:0] d, input logic useB, input logic hs);
		toPhase(4);
		iopId <= id;
		iopBuffer <= b;
		iopWrData <= d;
		readFlag <= rd;
		bufferSelectStrobe <= useB;
		@(posedge clk);
		bufferSelectStrobe <= 1'b1;
		hsReq.valid <= hs;
		@(posedge clk);
		bufferSelectStrobe <= 1'b0;
		hsReq.valid <= 1'b0;
		@(negedge clk);
	endtask

	task automatic hsRef(input logic ch, input logic [3:0] b, input logic wr,
		input logic [7:0] cb, input logic [63:0] d);
		toPhase(5);
		hsReq <= '{valid:1'b1, chan:ch, buffer:b, useB:1'b0, write:wr,
			check:cb, data:d};
		@(posedge clk);
		hsReq.valid <= 1'b0;
		hsReq.data <= ~d;
		@(negedge clk);
	endtask

	task automatic caOne(input logic wr, input logic ub, input logic [71:0] w,
		input logic [15:0] a);
		toPhase(3);
		ca.push('{adapter:4'h2, useB:ub, write:wr, data:w});
		toPhase(3);
		@(negedge clk);
		chk(memAddr, a);
		chk(memSource, SRC_CA);
		@(negedge clk);
		chk(caRd.valid, !wr);
		if (!wr) begin
			chk(caRd.word, w);
			chk(caRd.buffer, 4'h2);
			chk({caRd.single, caRd.dbl}, 2'b00);
		end
	endtask

	task automatic sSync;
		int n;
		n = 0;
		toPhase(0);
		do begin
			@(negedge clk);
			n++;
		end while (syncPulse !== 1'b1 && n < 20);
		chk(n, 6);
	endtask

	task automatic sIop;
		ld(4'h5, PTR_UA, 1'b0, 16'h0010);
		iopRef(2'h1, 4'h5, 1'b0, D1, 1'b0, 1'b0);
		chk({iopReject, iopAbort}, 2'b00);
		chk(memAddr, 16'h0010);
		chk(memSource, SRC_IOP);
		iopRef(2'h1, 4'h5, 1'b0, D2, 1'b0, 1'b0);
		chk(memAddr, 16'h0011);
		ld(4'h5, PTR_UA, 1'b0, 16'h0010);
		iopRef(2'h1, 4'h5, 1'b1, '0, 1'b0, 1'b0);
		@(negedge clk);
		chk(iopRd.valid, 1'b1);
		chk(iopRd.word[63:0], D1);
		chk({iopRd.single, iopRd.dbl}, 2'b00);
		cb1 = iopRd.word[71:64];
		ld(4'h5, PTR_UB, 1'b0, 16'h0200);
		iopRef(2'h1, 4'h5, 1'b0, D2, 1'b1, 1'b0);
		chk(memAddr, 16'h0200);
	endtask

	// Foreign processors must neither write nor step pointer A
	task automatic sReject;
		for (int i = 0; i < 4; i++)
			if (i != 1) begin
				iopRef(2'(i), 4'h5, 1'b0, 64'h0, 1'b0, 1'b0);
				chk(iopReject, 1'b1);
			end
		iopRef(2'h1, 4'h5, 1'b1, '0, 1'b0, 1'b0);
		@(negedge clk);
		chk(iopRd.word[63:0], D2);
	endtask

	task automatic sHs;
		ld(4'h5, PTR_UA, 1'b0, 16'h0040);
		hsRef(1'b1, 4'h5, 1'b1, cb1, D1 ^ 64'h1);
		chk(hsInStatus, 2'b10);
		chk(hsLocal, 1'b0);
		chk(memSource, SRC_HS_REMOTE);
		chk(memAddr, 16'h0040);
		hsRef(1'b0, 4'h5, 1'b1, cb1, D1 ^ 64'h3);
		chk(hsInStatus, 2'b01);
		chk(hsLocal, 1'b1);
		chk(memSource, SRC_HS_LOCAL);
		hsRef(1'b1, 4'hA, 1'b1, cb1, D1);
		chk({hsLocal, hsInStatus}, 3'b100);
		ld(4'h5, PTR_UA, 1'b0, 16'h0040);
		hsRef(1'b0, 4'h5, 1'b0, 8'h00, 64'h0);
		@(negedge clk);
		chk(hsRd.valid, 1'b1);
		chk(hsRd.word[63:0], D1);
		chk({hsRd.single, hsRd.dbl}, 2'b00);
		iopRef(2'h1, 4'h5, 1'b1, '0, 1'b0, 1'b1);
		chk(iopAbort, 1'b1);
		chk(memSource, SRC_HS_LOCAL);
		@(negedge clk);
		chk(iopRd.valid, 1'b0);
	endtask

	task automatic sCa;
		ld(4'h2, PTR_LA, 1'b1, 16'h0020);
		caOne(1'b1, 1'b0, W1, 16'h0020);
		caOne(1'b1, 1'b0, ~W1, 16'h001F);
		ld(4'h2, PTR_LA, 1'b1, 16'h0020);
		caOne(1'b0, 1'b0, W1, 16'h0020);
		caOne(1'b0, 1'b0, ~W1, 16'h001F);
		// Pointer b walks upward on its own while pointer a is set to step down
		ld(4'h2, PTR_LB, 1'b0, 16'h0100);
		caOne(1'b1, 1'b1, ~W1, 16'h0100);
		caOne(1'b1, 1'b1, W1, 16'h0101);
		ld(4'h2, PTR_LB, 1'b0, 16'h0100);
		caOne(1'b0, 1'b1, ~W1, 16'h0100);
		caOne(1'b0, 1'b1, W1, 16'h0101);
	endtask

	// 48 pushes outrun a one-per-sync drain; then drain with a slow partner
	task automatic sFill;
		int n;
		for (int i = 0; i < 48; i++)
			ca.push('{adapter:4'h3, useB:1'b0, write:1'b1, data:72'(i)});
		n = 0;
		while (caReqReady !== 1'b0 && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk(caReqReady, 1'b0);
		@(posedge clk);
		slow <= 1'b1;
		n = 0;
		while (memAddr !== 16'h002F && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk(memAddr, 16'h002F);
		chk(caReqReady, 1'b1);
	endtask

	initial begin
		repeat (20) @(posedge clk);
		chk(memSource, SRC_CA);
		chk(caReqReady, 1'b1);
		rst_b <= 1'b1;
		sSync;
		sIop;
		sReject;
		sHs;
		sCa;
		sFill;
		wrapUp;
	end

	initial begin
		#2000000;
		miscompares++;
		$display("BAD %0t watchdog expired", $time);
		wrapUp;
	end
endmodule

`default_nettype wire
